/* ouvf_pkg.sv */
// Package for the output under-voltage fault supervision block
// What this block does
// - Hold a 16-bit unsigned under-voltage fault threshold, exponent -11 volts.
// - Action 00: keep running through an under-voltage fault.
// - Action 01: keep running for the delay, then apply retry setting.
// - Action 10: shut output at once, then apply retry setting.
// - Action 11: output off while fault present, back on when gone.
// - Clear latched fault by bit clear, clear-all, reset, off-on, bias loss.
// - Retry 000: no restart, output stays off until fault cleared.
// - Retry 001 to 110: restart that many times, then stay off.
// - Restart attempts start spaced by 2**field delay units.
// - Retry 111: restart without any count limit.
// - Delay field decodes as 2 to the power of field delay units.
// - Continuous retry stops only on off command, bias loss, other fault.
package ouvf_pkg;
    localparam logic [7:0]  OUVF_THRESH_ADDR   = 8'h44;
    localparam logic [7:0]  OUVF_ACTION_ADDR   = 8'h45;
    localparam logic [15:0] OUVF_THRESH_RESET  = 16'h0000;
    localparam logic [7:0]  OUVF_ACTION_RESET  = 8'h00;
    localparam int          OUVF_VOUT_EXP      = -11;
    localparam logic [2:0]  OUVF_RETRY_NONE    = 3'h0;
    localparam logic [2:0]  OUVF_RETRY_FOREVER = 3'h7;
    localparam int          OUVF_UNIT_NS       = 1000;
    localparam int          OUVF_CLK_NS        = 5;
    localparam int          OUVF_UNIT_CYC      = (OUVF_UNIT_NS + OUVF_CLK_NS - 1) / OUVF_CLK_NS;
    localparam int          OUVF_START_CYC     = 20;

    typedef enum logic [1:0] {
        OUVF_RESP_IGNORE,
        OUVF_RESP_DELAY,
        OUVF_RESP_SHUTDOWN,
        OUVF_RESP_HOLD
    } ouvf_resp_t;

    typedef struct packed {
        ouvf_resp_t  resp;
        logic [2:0]  retries;
        logic [2:0]  delay;
    } ouvf_action_t;

    typedef struct packed {
        logic        wr;
        logic [7:0]  addr;
        logic [15:0] data;
    } ouvf_wr_t;
endpackage

/* ouvf_timer.sv */
// Delay timer counting 2**field units of the fault delay time
`timescale 1ns/10ps
`default_nettype none
module ouvf_timer
    import ouvf_pkg::*;
(
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    input  wire logic       start_i,
    input  wire logic [2:0] field_i,
    output logic            done_o
);
    logic [31:0] cnt;
    logic [31:0] next_cnt;
    logic        run;
    logic        next_run;
    logic        next_done;

    // Load 2**field units on start, count down, pulse done at zero
    always_comb begin
        next_cnt  = cnt;
        next_run  = run;
        next_done = 1'b0;
        if (start_i) begin
            next_cnt = ((32'h0000_0001 << field_i) * 32'(OUVF_UNIT_CYC)) - 32'h0000_0001;
            next_run = 1'b1;
        end else if (run) begin
            if (cnt == 32'h0000_0000) begin
                next_run  = 1'b0;
                next_done = 1'b1;
            end else begin
                next_cnt = cnt - 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt    <= 32'h0000_0000;
            run    <= 1'b0;
            done_o <= 1'b0;
        end else begin
            cnt    <= next_cnt;
            run    <= next_run;
            done_o <= next_done;
        end
    end
endmodule
`default_nettype wire

/* ouvf_top.sv */
// Output under-voltage fault supervision with threshold and action registers
`timescale 1ns/10ps
`default_nettype none
module ouvf_top
    import ouvf_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    input  wire logic        reg_wr_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [15:0] reg_wdata_i,
    output logic      [15:0] reg_rdata_o,
    input  wire logic [15:0] vout_meas_i,
    input  wire logic        fault_bit_clr_i,
    input  wire logic        clear_faults_i,
    input  wire logic        output_on_cmd_i,
    input  wire logic        bias_ok_i,
    input  wire logic        other_fault_i,
    output logic             output_en_o,
    output logic             uv_fault_o,
    output logic             uv_latched_o
);
    typedef enum {ST_RUN, ST_WAIT_DLY, ST_OFF_WAIT, ST_RESTART, ST_HOLD, ST_LATCHED} ouvf_st_t;

    logic         rst_s1, rst_n;
    logic         on_s1, on_s2, bias_s1, bias_s2, oth_s1, oth_s2;
    logic         on_d;
    ouvf_wr_t     wr;
    logic [15:0]  thresh, next_thresh;
    ouvf_action_t act, next_act;
    logic [15:0]  next_rdata;
    ouvf_st_t     st, next_st;
    logic [2:0]   tries, next_tries;
    logic [7:0]   scnt, next_scnt;
    logic         next_en, next_latch, latch;
    logic         tmr_start, tmr_done, uv, clr;

    assign wr = '{wr: reg_wr_i, addr: reg_addr_i, data: reg_wdata_i};

    // Reset released through two flops so removal is glitch free
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_s1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n  <= rst_s1;
        end
    end

    // Pin levels synchronised before use
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            on_s1   <= 1'b0;
            on_s2   <= 1'b0;
            bias_s1 <= 1'b0;
            bias_s2 <= 1'b0;
            oth_s1  <= 1'b0;
            oth_s2  <= 1'b0;
            on_d    <= 1'b0;
        end else begin
            on_s1   <= output_on_cmd_i;
            on_s2   <= on_s1;
            bias_s1 <= bias_ok_i;
            bias_s2 <= bias_s1;
            oth_s1  <= other_fault_i;
            oth_s2  <= oth_s1;
            on_d    <= on_s2;
        end
    end

    // Measurement comes from on-chip logic on this clock; threshold is Vout mode
    assign uv = vout_meas_i < thresh;
    // Any clear source; an off-to-on edge of the command counts as a clear
    assign clr = fault_bit_clr_i | clear_faults_i | (on_s2 & ~on_d) | ~bias_s2;

    // Register writes and readback
    always_comb begin
        next_thresh = thresh;
        next_act    = act;
        if (wr.wr && wr.addr == OUVF_THRESH_ADDR) begin
            next_thresh = wr.data;
        end else if (wr.wr && wr.addr == OUVF_ACTION_ADDR) begin
            next_act = ouvf_action_t'(wr.data[7:0]);
        end
        if (reg_addr_i == OUVF_THRESH_ADDR) begin
            next_rdata = thresh;
        end else if (reg_addr_i == OUVF_ACTION_ADDR) begin
            next_rdata = {8'h00, act};
        end else begin
            next_rdata = 16'h0000;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            thresh      <= OUVF_THRESH_RESET;
            act         <= ouvf_action_t'(OUVF_ACTION_RESET);
            reg_rdata_o <= 16'h0000;
        end else begin
            thresh      <= next_thresh;
            act         <= next_act;
            reg_rdata_o <= next_rdata;
        end
    end

    ouvf_timer u_timer (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n),
        .start_i (tmr_start),
        .field_i (act.delay),
        .done_o  (tmr_done)
    );

    // Response sequencer
    always_comb begin
        next_st    = st;
        next_tries = tries;
        next_scnt  = scnt;
        next_latch = latch;
        tmr_start  = 1'b0;
        next_en    = output_en_o;
        case (st)
            ST_RUN: begin
                next_en = 1'b1;
                if (uv) begin
                    next_latch = 1'b1;
                    next_tries = 3'h0;
                    case (act.resp)
                        OUVF_RESP_IGNORE: next_st = ST_RUN;
                        OUVF_RESP_DELAY: begin
                            tmr_start = 1'b1;
                            next_st   = ST_WAIT_DLY;
                        end
                        OUVF_RESP_SHUTDOWN: begin
                            next_en = 1'b0;
                            if (act.retries == OUVF_RETRY_NONE) begin
                                next_st = ST_LATCHED;
                            end else begin
                                tmr_start = 1'b1;
                                next_st   = ST_OFF_WAIT;
                            end
                        end
                        default: begin
                            next_en = 1'b0;
                            next_st = ST_HOLD;
                        end
                    endcase
                end
            end
            ST_WAIT_DLY: begin
                if (!uv) begin
                    next_st = ST_RUN;
                end else if (tmr_done) begin
                    next_en = 1'b0;
                    if (act.retries == OUVF_RETRY_NONE) begin
                        next_st = ST_LATCHED;
                    end else begin
                        tmr_start = 1'b1;
                        next_st   = ST_OFF_WAIT;
                    end
                end
            end
            ST_OFF_WAIT: begin
                next_en = 1'b0;
                if (tmr_done) begin
                    next_en    = 1'b1;
                    next_tries = tries + 3'h1;
                    // Timer reloads at each attempt so attempt starts sit one delay apart
                    tmr_start  = 1'b1;
                    next_scnt  = 8'(OUVF_START_CYC);
                    next_st    = ST_RESTART;
                end
            end
            ST_RESTART: begin
                // Soft start settles before judging; settle must stay below one delay unit
                if (scnt != 8'h00) begin
                    next_scnt = scnt - 8'h01;
                end else if (!uv) begin
                    next_st = ST_RUN;
                end else begin
                    next_en = 1'b0;
                    if (act.retries == OUVF_RETRY_FOREVER || tries < act.retries) begin
                        // Off time is what is left of the delay begun at this attempt
                        next_st = ST_OFF_WAIT;
                    end else begin
                        next_st = ST_LATCHED;
                    end
                end
            end
            ST_HOLD: begin
                next_en = 1'b0;
                if (!uv) begin
                    next_en = 1'b1;
                    next_st = ST_RUN;
                end
            end
            default: begin
                next_en = 1'b0;
                if (clr) begin
                    next_st = ST_RUN;
                end
            end
        endcase
        // Off command, bias loss or another fault ends any retry cycle
        if (!on_s2 || !bias_s2 || oth_s2) begin
            next_en   = 1'b0;
            next_st   = (st == ST_RUN || st == ST_LATCHED) ? st : ST_LATCHED;
            tmr_start = 1'b0;
        end
        // Bias loss is itself a clear, so the sequencer comes back in run state
        if (!bias_s2) begin
            next_st = ST_RUN;
        end
        // A new fault in the clearing cycle wins over the clear
        if (clr && !(uv && st == ST_RUN)) begin
            next_latch = 1'b0;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            st           <= ST_RUN;
            tries        <= 3'h0;
            scnt         <= 8'h00;
            latch        <= 1'b0;
            output_en_o  <= 1'b0;
            uv_fault_o   <= 1'b0;
            uv_latched_o <= 1'b0;
        end else begin
            st           <= next_st;
            tries        <= next_tries;
            scnt         <= next_scnt;
            latch        <= next_latch;
            output_en_o  <= next_en & on_s2 & bias_s2;
            uv_fault_o   <= uv;
            uv_latched_o <= next_latch;
        end
    end
endmodule
`default_nettype wire

/* ouvf_props.sv */
// Port checker for the output under-voltage fault block
`timescale 1ns/10ps
`default_nettype none
module ouvf_props
    import ouvf_pkg::*;
(
    input wire logic        mclk_i,
    input wire logic        rst_n_i,
    input wire logic        reg_wr_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic [15:0] vout_meas_i,
    input wire logic        output_on_cmd_i,
    input wire logic        bias_ok_i,
    input wire logic        other_fault_i,
    input wire logic        clear_faults_i,
    input wire logic        fault_bit_clr_i,
    input wire logic        output_en_o,
    input wire logic        uv_fault_o,
    input wire logic        uv_latched_o
);
    logic [15:0] thr_q;
    logic [7:0]  act_q;
    logic [2:0]  ok_q;
    // Register shadows; ok_q hides the sync lag of the control pins
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            thr_q <= 16'h0000;
            act_q <= 8'h00;
            ok_q  <= 3'd0;
        end else begin
            if (reg_wr_i && reg_addr_i == OUVF_THRESH_ADDR) thr_q <= reg_wdata_i;
            if (reg_wr_i && reg_addr_i == OUVF_ACTION_ADDR) act_q <= reg_wdata_i[7:0];
            ok_q <= !(output_on_cmd_i && bias_ok_i && !other_fault_i) ? 3'd0
                  : (ok_q == 3'd7) ? ok_q : ok_q + 3'd1;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    property p_rd_unmapped;
        reg_addr_i != OUVF_THRESH_ADDR && reg_addr_i != OUVF_ACTION_ADDR |=> reg_rdata_o == 16'h0000;
    endproperty
    property p_rd_thresh;
        (reg_wr_i && reg_addr_i == OUVF_THRESH_ADDR) ##1 (reg_addr_i == OUVF_THRESH_ADDR)
            |=> reg_rdata_o == $past(reg_wdata_i, 2);
    endproperty
    property p_uv_cmp;
        uv_fault_o == ($past(vout_meas_i) < $past(thr_q));
    endproperty
    property p_ignore;
        ok_q == 3'd7 && act_q[7:6] == 2'b00 && output_en_o |=> output_en_o;
    endproperty
    property p_shut;
        $rose(uv_fault_o) && act_q[7] |-> !output_en_o;
    endproperty
    property p_hold_resume;
        act_q[7:6] == 2'b11 && $fell(uv_fault_o) && ok_q == 3'd7 |-> ##[1:30] output_en_o;
    endproperty
    property p_clear;
        (clear_faults_i || fault_bit_clr_i) && !reg_wr_i && !uv_fault_o
            && vout_meas_i >= thr_q |=> !uv_latched_o;
    endproperty
    property p_bias;
        !bias_ok_i [*5] |-> !output_en_o;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
    a_rd_thresh: assert property (p_rd_thresh) else $error("threshold readback wrong");
    a_uv_cmp: assert property (p_uv_cmp) else $error("fault flag wrong");
    a_ignore: assert property (p_ignore) else $error("output dropped");
    a_shut: assert property (p_shut) else $error("no shutdown");
    a_hold_resume: assert property (p_hold_resume) else $error("no resume");
    a_clear: assert property (p_clear) else $error("latch not cleared");
    a_bias: assert property (p_bias) else $error("on without bias");
    c_shut: cover property ($fell(output_en_o) && act_q[7:6] == 2'b10);
    c_delay: cover property ($fell(output_en_o) && act_q[7:6] == 2'b01);
    c_forever: cover property ($rose(output_en_o) && act_q[5:3] == 3'd7);
endmodule
bind ouvf_top ouvf_props u_props (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .vout_meas_i(vout_meas_i), .output_on_cmd_i(output_on_cmd_i), .bias_ok_i(bias_ok_i),
    .other_fault_i(other_fault_i), .clear_faults_i(clear_faults_i),
    .fault_bit_clr_i(fault_bit_clr_i), .output_en_o(output_en_o), .uv_fault_o(uv_fault_o),
    .uv_latched_o(uv_latched_o));
`default_nettype wire

/* ouvf_host_model.sv */
// Management host model that writes and reads the fault registers
`timescale 1ns/10ps
`default_nettype none
module ouvf_host_model (
    input  wire logic        mclk_i,
    output logic             wr_o,
    output logic      [7:0]  addr_o,
    output logic      [15:0] wdata_o,
    input  wire logic [15:0] rdata_i
);
    initial begin
        wr_o = 1'b0;
        addr_o = 8'h00;
        wdata_o = 16'h0000;
    end
    // One-cycle strobe; held across the taking edge, low a cycle after
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge mclk_i);
        wr_o = 1'b1;
        addr_o = a;
        wdata_o = d;
        @(negedge mclk_i);
        wr_o = 1'b0;
        wdata_o = ~d;
    endtask
    // Readback is registered, so wait two edges with the address held
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(negedge mclk_i);
        addr_o = a;
        repeat (2) @(negedge mclk_i);
        d = rdata_i;
    endtask
endmodule
`default_nettype wire

/* ouvf_tb_top.sv */
// Self-checking testbench for the under-voltage fault block
`timescale 1ns/10ps
`default_nettype none
module ouvf_tb_top
    import ouvf_pkg::*;
;
    logic        mclk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        wr, en, uvf, lat;
    logic        bclr = 1'b0, clr = 1'b0, on = 1'b1, bias = 1'b1, oth = 1'b0;
    logic [7:0]  addr;
    logic [15:0] wdata, rdata, d;
    logic [15:0] vout = 16'h6000;
    int          mismatches = 0, total_checks = 0, n;
    always #2.5 mclk_i = ~mclk_i;
    ouvf_host_model host (.mclk_i(mclk_i), .wr_o(wr), .addr_o(addr), .wdata_o(wdata),
        .rdata_i(rdata));
    ouvf_top dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_wr_i(wr), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata), .vout_meas_i(vout),
        .fault_bit_clr_i(bclr), .clear_faults_i(clr), .output_on_cmd_i(on),
        .bias_ok_i(bias), .other_fault_i(oth), .output_en_o(en), .uv_fault_o(uvf),
        .uv_latched_o(lat));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Counts falling edges until the output reaches v, capped at lim
    task automatic wait_en(input logic v, input int lim, output int k);
        k = 0;
        while (en !== v && k < lim) begin
            @(negedge mclk_i);
            k++;
        end
    endtask
    // Fresh reset per test keeps latched state from leaking between tests
    task automatic restart(input logic [7:0] act);
        rst_n_i = 1'b0;
        repeat (8) @(negedge mclk_i);
        rst_n_i = 1'b1;
        repeat (10) @(negedge mclk_i);
        chk("en_after_reset", 16'h0001, {15'h0000, en});
        host.wr(OUVF_THRESH_ADDR, 16'h5000);
        host.wr(OUVF_ACTION_ADDR, {8'h00, act});
    endtask
    task automatic t_regs;
        restart(8'h00);
        host.rd(OUVF_ACTION_ADDR, d);
        chk("act", 16'h0000, d);
        host.wr(OUVF_THRESH_ADDR, 16'hA5C3);
        host.wr(8'h46, 16'hFFFF);
        host.rd(OUVF_THRESH_ADDR, d);
        chk("thr", 16'hA5C3, d);
        host.rd(8'h46, d);
        chk("unmapped", 16'h0000, d);
        chk("uv_flag", 16'h0001, {15'h0000, uvf});
        wait_en(1'b0, 300, n);
        chk("ignore_run", 16'd300, n[15:0]);
        $display("t_regs done");
    endtask
    task automatic t_delay;
        restart(8'h41);
        vout = 16'h4000;
        wait_en(1'b0, 600, n);
        chk("delay_len", 16'h0001, 16'(n >= 398 && n <= 406));
        wait_en(1'b1, 500, n);
        chk("no_retry", 16'd500, n[15:0]);
        chk("latched", 16'h0001, {15'h0000, lat});
        vout = 16'h6000;
        @(negedge mclk_i);
        clr = 1'b1;
        @(negedge mclk_i);
        clr = 1'b0;
        repeat (3) @(negedge mclk_i);
        chk("clear_all", 16'h0000, {15'h0000, lat});
        $display("t_delay done");
    endtask
    // Delayed response with two retries, one delay unit apart
    task automatic t_dly_retry;
        int m;
        restart(8'h50);
        vout = 16'h4000;
        wait_en(1'b0, 300, n);
        chk("dly_unit", 16'h0001, 16'(n >= 198 && n <= 206));
        wait_en(1'b1, 300, n);
        chk("dly_first_retry", 16'h0001, 16'(n >= 198 && n <= 206));
        wait_en(1'b0, 40, m);
        wait_en(1'b1, 300, n);
        chk("dly_spacing", 16'h0001, 16'(m + n >= 198 && m + n <= 206));
        wait_en(1'b0, 40, m);
        wait_en(1'b1, 600, n);
        chk("dly_gave_up", 16'd600, n[15:0]);
        vout = 16'h6000;
        $display("t_dly_retry done");
    endtask
    task automatic t_retry;
        restart(8'h88);
        vout = 16'h4000;
        wait_en(1'b0, 4, n);
        chk("shut", 16'h0001, 16'(n <= 3));
        wait_en(1'b1, 300, n);
        chk("spacing", 16'h0001, 16'(n >= 197 && n <= 204));
        wait_en(1'b0, 40, n);
        wait_en(1'b1, 1000, n);
        chk("gave_up", 16'd1000, n[15:0]);
        chk("retry_latched", 16'h0001, {15'h0000, lat});
        vout = 16'h6000;
        @(negedge mclk_i);
        bclr = 1'b1;
        @(negedge mclk_i);
        bclr = 1'b0;
        repeat (3) @(negedge mclk_i);
        chk("bit_clear", 16'h0000, {15'h0000, lat});
        $display("t_retry done");
    endtask
    task automatic t_forever;
        restart(8'hB8);
        vout = 16'h4000;
        wait_en(1'b0, 4, n);
        chk("forever_shut", 16'h0001, 16'(n <= 3));
        for (int i = 0; i < 4; i++) begin
            wait_en(1'b1, 300, n);
            chk("restart", 16'h0001, 16'(n < 300));
            wait_en(1'b0, 40, n);
        end
        oth = 1'b1;
        wait_en(1'b1, 600, n);
        chk("other_stop", 16'd600, n[15:0]);
        oth = 1'b0;
        vout = 16'h6000;
        on = 1'b0;
        repeat (6) @(negedge mclk_i);
        on = 1'b1;
        repeat (8) @(negedge mclk_i);
        chk("off_on_clear", 16'h0000, {15'h0000, lat});
        bias = 1'b0;
        repeat (8) @(negedge mclk_i);
        chk("bias_off", 16'h0000, {15'h0000, en});
        bias = 1'b1;
        $display("t_forever done");
    endtask
    task automatic t_hold;
        restart(8'hC0);
        vout = 16'h4000;
        wait_en(1'b0, 4, n);
        chk("hold_off", 16'h0001, 16'(n <= 3));
        vout = 16'h6000;
        wait_en(1'b1, 30, n);
        chk("hold_back", 16'h0001, 16'(n < 30));
        $display("t_hold done");
    endtask
    task automatic tally_and_finish;
        $display("Checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        t_regs();
        t_delay();
        t_dly_retry();
        t_retry();
        t_forever();
        t_hold();
        tally_and_finish();
    end
    // All tests need about 27 us; a hang stops well past that
    initial begin
        #200us;
        mismatches++;
        $display("Watchdog expired");
        tally_and_finish();
    end
endmodule
`default_nettype wire
